// ===== inc/touch_pkg.sv
// shared constants and types for the four-channel touch detector
package touch_pkg;
  // clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int DETECT_MS = 16;
  localparam int CAL_S = 2;
  localparam int AC_SHORT_MS = 8;
  localparam int AC_LONG_MS = 32;
  localparam int DETECT_CYC = CLK_HZ / 1000 * DETECT_MS;
  localparam int CAL_CYC = CLK_HZ * CAL_S;
  localparam int AC_SHORT_CYC = CLK_HZ / 1000 * AC_SHORT_MS;
  localparam int AC_LONG_CYC = CLK_HZ / 1000 * AC_LONG_MS;
  localparam int TW = 28;
  // channels and measurement width
  localparam int NCH = 4;
  localparam int MEAS_W = 10;
  // register offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_CHAN_CTRL = 8'h01;
  localparam logic [7:0] REG_PRESSED = 8'h02;
  localparam logic [7:0] REG_CHANGE = 8'h03;
  localparam logic [7:0] REG_IRQ_CFG = 8'h04;
  // field positions
  localparam int CFG_SSD_BIT = 0;
  localparam int CFG_SENS_LO = 2;
  localparam int IRQ_AC_LO = 6;
  // reset values
  localparam logic CONFIG_SSD_RST = 1'b0;
  localparam logic [1:0] CONFIG_SENS_RST = 2'h0;
  localparam logic [3:0] CHAN_EN_RST = 4'hf;
  localparam logic [1:0] IRQ_AC_RST = 2'h0;
  // sensitivity and auto-clear codes
  localparam logic [1:0] SENS_HIGH = 2'h1;
  localparam logic [1:0] SENS_LOW = 2'h2;
  localparam logic [1:0] AC_SHORT = 2'h1;
  localparam logic [1:0] AC_LONG = 2'h2;
  // thresholds in measurement steps
  localparam logic [MEAS_W:0] THR_NORMAL = 11'h020;
  localparam logic [MEAS_W:0] THR_HIGH = 11'h010;
  localparam logic [MEAS_W:0] THR_LOW = 11'h040;
  // serial bus
  localparam logic [6:0] DEV_ADDR_DEF = 7'h50;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_dev = 3'b001,
    st_dev_ack = 3'b011,
    st_wr = 3'b010,
    st_wr_ack = 3'b110,
    st_rd = 3'b111,
    st_rd_ack = 3'b101
  } bus_state_type;
endpackage

// ===== verilog/serial_reg_port.sv
// two-wire serial slave giving byte access to the register file
`timescale 1ns/10ps
module serial_reg_port #(
  parameter logic [6:0] DEV_ADDR = touch_pkg::DEV_ADDR_DEF
)(
  // system
  input wire logic ref_clk,
  input wire logic rst,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // register side
  output logic [7:0] reg_addr,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic rd_stb,
  input wire logic [7:0] rd_data
);
  import touch_pkg::*;
  logic scl1, scl2, scl3, sda1, sda2, sda3;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  bus_state_type state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic is_read, first_byte, nack;

  // pin synchronisers, third stage only for edges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {scl1, scl2, scl3} <= 3'h7;
      {sda1, sda2, sda3} <= 3'h7;
    end else begin
      {scl1, scl2, scl3} <= {scl_i, scl1, scl2};
      {sda1, sda2, sda3} <= {sda_i, sda1, sda2};
    end
  end

  // bus events
  assign scl_rise = scl2 & ~scl3;
  assign scl_fall = ~scl2 & scl3;
  assign start_seen = scl2 & scl3 & ~sda2 & sda3;
  assign stop_seen = scl2 & scl3 & sda2 & ~sda3;
  assign sda_o = 1'b0;
  assign wr_data = shift;

  // protocol engine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      is_read <= 1'b0;
      first_byte <= 1'b0;
      nack <= 1'b0;
      reg_addr <= 8'h00;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (start_seen) begin
        state <= st_dev;
        bit_cnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_seen) begin
        state <= st_idle;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (state == st_dev || state == st_wr) begin
          shift <= {shift[6:0], sda2};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (state == st_rd) begin
          bit_cnt <= bit_cnt + 4'h1;
        end else if (state == st_rd_ack) begin
          nack <= sda2;
        end
      end else if (scl_fall) begin
        case (state)
          st_dev: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              if (shift[7:1] == DEV_ADDR) begin
                state <= st_dev_ack;
                is_read <= shift[0];
                sda_oe_n <= 1'b0;
              end else begin
                state <= st_idle;
              end
            end
          end
          st_dev_ack: begin
            bit_cnt <= 4'h0;
            first_byte <= 1'b1;
            if (is_read) begin
              state <= st_rd;
              shift <= rd_data;
              sda_oe_n <= rd_data[7];
              rd_stb <= 1'b1;
            end else begin
              state <= st_wr;
              sda_oe_n <= 1'b1;
            end
          end
          st_wr: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              state <= st_wr_ack;
              sda_oe_n <= 1'b0;
              if (first_byte) begin
                reg_addr <= shift;
              end else begin
                wr_stb <= 1'b1;
              end
            end
          end
          st_wr_ack: begin
            state <= st_wr;
            bit_cnt <= 4'h0;
            sda_oe_n <= 1'b1;
            first_byte <= 1'b0;
            // the pointer byte itself must not advance the pointer
            if (!first_byte) begin
              reg_addr <= reg_addr + 8'h01;
            end
          end
          st_rd: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              state <= st_rd_ack;
              sda_oe_n <= 1'b1;
              reg_addr <= reg_addr + 8'h01;
            end else begin
              shift <= {shift[6:0], 1'b0};
              sda_oe_n <= shift[6];
            end
          end
          st_rd_ack: begin
            bit_cnt <= 4'h0;
            if (nack) begin
              state <= st_idle;
            end else begin
              state <= st_rd;
              shift <= rd_data;
              sda_oe_n <= rd_data[7];
              rd_stb <= 1'b1;
            end
          end
          default: begin
            state <= st_idle;
          end
        endcase
      end
    end
  end

  a_strobe_single: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_stb | wr_stb) |=> !(rd_stb | wr_stb))
    else $error("register strobe lasted more than one cycle");
endmodule

// ===== verilog/touch_detect_irq_logic.sv
// four-channel touch detection, status registers and interrupt line
`timescale 1ns/10ps
// Operation
// - auto-clear code 01 releases irq after 8 ms low, 10 after 32 ms
// - auto-clear field is irq-config bits 7:6, reset 00, low bits unused
// - sensitivity code 00 normal, 01 high, 10 low
// - touch needs count above reference by 32, 16 or 64 steps
// - detection cycle every 16 ms across all four inputs
// - state changes only after two consecutive differing detection cycles
// - calibration every 2 s refreshes reference values of enabled channels that are not pressed
// - open-drain channel output pulled low while channel pressed
// - pressed-state register holds one bit per channel
// - change register bit set when that channel's pressed state changes
// - any valid change pulls the interrupt line low
// - accessing the change register returns interrupt line high
// - shutdown keeps registers but stops detection
// - software shutdown bit set to 1 enters shutdown
// - shutdown pin low enters shutdown
// - channel enable bits reset to 1; disabled channels are ignored
module touch_detect_irq_logic #(
  parameter int DETECT_CYCLES = touch_pkg::DETECT_CYC,
  parameter int CAL_CYCLES = touch_pkg::CAL_CYC,
  parameter int AC_SHORT_CYCLES = touch_pkg::AC_SHORT_CYC,
  parameter int AC_LONG_CYCLES = touch_pkg::AC_LONG_CYC,
  parameter logic [6:0] DEV_ADDR = touch_pkg::DEV_ADDR_DEF
)(
  // system
  input wire logic ref_clk,
  input wire logic rst,
  // measurement front end
  input wire logic meas_clk,
  input wire logic [touch_pkg::NCH*touch_pkg::MEAS_W-1:0] sense_inputs,
  // shutdown pin
  input wire logic shutdown_pin_n,
  // serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // interrupt
  output logic touch_irq_n,
  // channel outputs
  input wire logic [touch_pkg::NCH-1:0] touch_out_i,
  output logic [touch_pkg::NCH-1:0] touch_out_o,
  output logic [touch_pkg::NCH-1:0] touch_out_oe_n
);
  import touch_pkg::*;

  function automatic logic [MEAS_W:0] threshold(input logic [1:0] sel);
    logic [MEAS_W:0] t;
    case (sel)
      SENS_HIGH: t = THR_HIGH;
      SENS_LOW: t = THR_LOW;
      default: t = THR_NORMAL; // code 11 falls back to normal
    endcase
    return t;
  endfunction

  function automatic logic exceeds(input logic [MEAS_W-1:0] m, input logic [MEAS_W-1:0] r,
                                   input logic [1:0] sel);
    logic [MEAS_W:0] lim;
    lim = {1'b0, r} + threshold(sel);
    return {1'b0, m} >= lim;
  endfunction

  logic [7:0] reg_addr, wr_data, rd_data;
  logic wr_stb, rd_stb;
  logic soft_shutdown;
  logic [1:0] sens_sel, irq_autoclear_sel;
  logic [NCH-1:0] channel_enable, pressed_flag, change_flag, streak, flip;
  logic [MEAS_W-1:0] ref_val [NCH];
  logic sd1, sd2, shutdown;
  logic [TW-1:0] det_cnt, cal_cnt, ac_cnt;
  logic det_tick, cal_tick, cal_pending, cal_mode;
  logic req_tgl, a1, a2, a3, snap_done, busy, change_access, ac_release;
  logic m_req1, m_req2, m_ack;
  logic [NCH*MEAS_W-1:0] m_hold;

  serial_reg_port #(.DEV_ADDR(DEV_ADDR)) u_port (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .reg_addr(reg_addr),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_stb(rd_stb),
    .rd_data(rd_data)
  );

  // front-end side: capture a snapshot when asked, answer by toggle
  always_ff @(posedge meas_clk or posedge rst) begin
    if (rst) begin
      m_req1 <= 1'b0;
      m_req2 <= 1'b0;
      m_ack <= 1'b0;
      m_hold <= '0;
    end else begin
      m_req1 <= req_tgl;
      m_req2 <= m_req1;
      if (m_req2 != m_ack) begin
        m_hold <= sense_inputs;
        m_ack <= m_req2;
      end
    end
  end

  // answer toggle brought back; m_hold is frozen until the next request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {a1, a2, a3} <= 3'h0;
    end else begin
      {a1, a2, a3} <= {m_ack, a1, a2};
    end
  end
  assign snap_done = a2 ^ a3;
  assign busy = req_tgl ^ a2;

  // shutdown pin synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {sd1, sd2} <= 2'h3;
    end else begin
      {sd1, sd2} <= {shutdown_pin_n, sd1};
    end
  end
  assign shutdown = soft_shutdown | ~sd2;

  // writable registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      soft_shutdown <= CONFIG_SSD_RST;
      sens_sel <= CONFIG_SENS_RST;
      channel_enable <= CHAN_EN_RST;
      irq_autoclear_sel <= IRQ_AC_RST;
    end else if (wr_stb) begin
      case (reg_addr)
        REG_CONFIG: begin
          soft_shutdown <= wr_data[CFG_SSD_BIT];
          sens_sel <= wr_data[CFG_SENS_LO +: 2];
        end
        REG_CHAN_CTRL: channel_enable <= wr_data[NCH-1:0];
        REG_IRQ_CFG: irq_autoclear_sel <= wr_data[IRQ_AC_LO +: 2];
        default: ;
      endcase
    end
  end

  // read data
  always_comb begin
    case (reg_addr)
      REG_CONFIG: begin
        rd_data = 8'h00;
        rd_data[CFG_SSD_BIT] = soft_shutdown;
        rd_data[CFG_SENS_LO +: 2] = sens_sel;
      end
      REG_CHAN_CTRL: rd_data = {4'hf, channel_enable};
      REG_PRESSED: rd_data = {4'h0, pressed_flag};
      REG_CHANGE: rd_data = {4'h0, change_flag};
      REG_IRQ_CFG: rd_data = {irq_autoclear_sel, 6'h00};
      default: rd_data = 8'h00;
    endcase
  end

  // detection and calibration period timers, halted in shutdown
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      det_cnt <= '0;
      cal_cnt <= '0;
    end else if (!shutdown) begin
      det_cnt <= det_tick ? '0 : det_cnt + 1'b1;
      cal_cnt <= cal_tick ? '0 : cal_cnt + 1'b1;
    end
  end
  assign det_tick = !shutdown && det_cnt == TW'(DETECT_CYCLES - 1);
  assign cal_tick = !shutdown && cal_cnt == TW'(CAL_CYCLES - 1);

  // snapshot requests; a pending calibration takes the next slot
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_tgl <= 1'b0;
      cal_mode <= 1'b0;
      cal_pending <= 1'b1;
    end else begin
      if (det_tick && !busy) begin
        req_tgl <= ~req_tgl;
        cal_mode <= cal_pending;
      end
      if (cal_tick) begin
        cal_pending <= 1'b1;
      end else if (det_tick && !busy) begin
        cal_pending <= 1'b0;
      end
    end
  end

  // per-channel evaluation with a two-cycle filter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pressed_flag <= '0;
      streak <= '0;
      flip <= '0;
      for (int i = 0; i < NCH; i++) begin
        ref_val[i] <= '0;
      end
    end else begin
      flip <= '0;
      if (snap_done && !shutdown) begin
        for (int i = 0; i < NCH; i++) begin
          if (!channel_enable[i]) begin
            streak[i] <= 1'b0;
          end else if (cal_mode) begin
            if (!pressed_flag[i]) begin
              ref_val[i] <= m_hold[i*MEAS_W +: MEAS_W];
            end
          end else if (exceeds(m_hold[i*MEAS_W +: MEAS_W], ref_val[i], sens_sel)
                       == pressed_flag[i]) begin
            streak[i] <= 1'b0;
          end else if (streak[i]) begin
            pressed_flag[i] <= ~pressed_flag[i];
            flip[i] <= 1'b1;
            streak[i] <= 1'b0;
          end else begin
            streak[i] <= 1'b1;
          end
        end
      end
    end
  end

  // any access to the change register acknowledges
  assign change_access = (rd_stb | wr_stb) && reg_addr == REG_CHANGE;

  // change flags, a new change wins over the clearing access
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      change_flag <= '0;
    end else begin
      change_flag <= (change_access ? '0 : change_flag) | flip;
    end
  end

  // auto-clear timing while the line is low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ac_cnt <= '0;
    end else begin
      ac_cnt <= touch_irq_n ? '0 : ac_cnt + 1'b1;
    end
  end
  assign ac_release = !touch_irq_n &&
    ((irq_autoclear_sel == AC_SHORT && ac_cnt >= TW'(AC_SHORT_CYCLES - 1)) ||
     (irq_autoclear_sel == AC_LONG && ac_cnt >= TW'(AC_LONG_CYCLES - 1)));

  // interrupt line, set wins over release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      touch_irq_n <= 1'b1;
    end else if (|flip) begin
      touch_irq_n <= 1'b0;
    end else if (change_access || ac_release) begin
      touch_irq_n <= 1'b1;
    end
  end

  // open-drain channel outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      touch_out_o <= '0;
      touch_out_oe_n <= '1;
    end else begin
      touch_out_o <= '0;
      touch_out_oe_n <= ~pressed_flag;
    end
  end

  sequence s_change;
    $changed(pressed_flag);
  endsequence
  sequence s_quiet_irq;
    !(|flip) && !change_access;
  endsequence

  a_irq_on_change: assert property (@(posedge ref_clk) disable iff (rst)
    s_change |=> !touch_irq_n)
    else $error("interrupt not asserted after a state change");
  a_change_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
    s_change |=> (change_flag & (pressed_flag ^ $past(pressed_flag, 2))) != '0)
    else $error("change flag not set on a state change");
  a_irq_ack_read: assert property (@(posedge ref_clk) disable iff (rst)
    (change_access && !(|flip)) |=> touch_irq_n)
    else $error("interrupt not released by change register access");
  a_output_follows: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(pressed_flag[0]) |=> !touch_out_oe_n[0])
    else $error("channel output not pulled low when pressed");
  a_two_cycle_filter: assert property (@(posedge ref_clk) disable iff (rst)
    s_change |-> $past(streak) != '0)
    else $error("state changed without a prior differing cycle");
  a_shutdown_hold: assert property (@(posedge ref_clk) disable iff (rst)
    shutdown |=> $stable(pressed_flag))
    else $error("detection ran during shutdown");
  a_soft_shutdown: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_stb && reg_addr == REG_CONFIG && wr_data[CFG_SSD_BIT]) |=> shutdown)
    else $error("software shutdown not entered");
  a_pin_shutdown: assert property (@(posedge ref_clk) disable iff (rst)
    !shutdown_pin_n [*3] |-> shutdown)
    else $error("pin shutdown not entered");
  a_disabled_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !channel_enable[0] |=> $stable(pressed_flag[0]))
    else $error("disabled channel changed state");
  a_autoclear_short: assert property (@(posedge ref_clk) disable iff (rst)
    (irq_autoclear_sel == AC_SHORT && !touch_irq_n && !(|flip) &&
     ac_cnt == TW'(AC_SHORT_CYCLES - 1)) |=> touch_irq_n)
    else $error("auto-clear did not release in time");
  a_invalid_ac_holds: assert property (@(posedge ref_clk) disable iff (rst)
    s_quiet_irq ##0 (irq_autoclear_sel == 2'h3 && !touch_irq_n) |=> !touch_irq_n)
    else $error("invalid auto-clear code released the interrupt");
endmodule

// ===== verif/i2c_host_model.sv
// host controller model driving the two-wire register bus
`timescale 1ns/10ps
module i2c_host_model #(
  parameter int Q = 8
)(
  // system
  input wire logic ref_clk,
  // bus pins
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // bus idles released, pull-up holds it high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // data moves only while scl is low, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    w(Q);
    scl <= 1'b1;
    w(Q);
    r = sda_line;
    scl <= 1'b0;
    w(Q);
  endtask
  // start and repeated start
  task automatic start();
    sda_drv <= 1'b1;
    w(Q);
    scl <= 1'b1;
    w(Q);
    sda_drv <= 1'b0;
    w(Q);
    scl <= 1'b0;
    w(Q);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    w(Q);
    scl <= 1'b1;
    w(Q);
    sda_drv <= 1'b1;
    w(Q);
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r,
                         output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(a, ack);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                           output logic nack);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    byte_io({dev, 1'b0}, 1'b1, r, a0);
    byte_io(p, 1'b1, r, a1);
    byte_io(d, 1'b1, r, a2);
    stop();
    nack = a0 | a1 | a2;
  endtask
  // two-byte read from pointer, last byte refused to end the transfer
  task automatic read2(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d0,
                       output logic [7:0] d1, output logic nack);
    logic [7:0] r;
    logic a0, a1, a2, x;
    start();
    byte_io({dev, 1'b0}, 1'b1, r, a0);
    byte_io(p, 1'b1, r, a1);
    start();
    byte_io({dev, 1'b1}, 1'b1, r, a2);
    byte_io(8'hff, 1'b0, d0, x);
    byte_io(8'hff, 1'b1, d1, x);
    stop();
    nack = a0 | a1 | a2;
  endtask
endmodule

// ===== verif/touch_detect_irq_logic_test.sv
// self-checking bench for the touch detector
`timescale 1ns/10ps
module touch_detect_irq_logic_test;
  import touch_pkg::*;
  localparam int DC = 50;
  localparam int CC = 6000;
  localparam int ASC = 20;
  localparam int ALC = 80;
  localparam logic [9:0] BASE = 10'h064;
  logic ref_clk = 1'b0;
  logic meas_clk = 1'b0;
  logic rst = 1'b1;
  logic shutdown_pin_n = 1'b1;
  logic [39:0] sense_inputs = {4{BASE}};
  logic scl, sda_drv, sda_o, sda_oe_n, touch_irq_n;
  logic [3:0] touch_out_o, touch_out_oe_n;
  logic [7:0] d0, d1;
  logic nk;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // open-drain line with pull-up
  wire logic sda_line = sda_drv & (sda_oe_n | sda_o);
  // clocks, measurement clock offset in phase
  always #5 ref_clk = ~ref_clk;
  initial #3.1 forever #40 meas_clk = ~meas_clk;
  // cycles since reset, locates calibration points
  always @(posedge ref_clk) cyc <= rst ? 0 : cyc + 1;
  touch_detect_irq_logic #(.DETECT_CYCLES(DC), .CAL_CYCLES(CC), .AC_SHORT_CYCLES(ASC),
    .AC_LONG_CYCLES(ALC)) dut (.ref_clk(ref_clk), .rst(rst), .meas_clk(meas_clk),
    .sense_inputs(sense_inputs), .shutdown_pin_n(shutdown_pin_n), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .touch_irq_n(touch_irq_n),
    .touch_out_i(touch_out_oe_n | touch_out_o), .touch_out_o(touch_out_o),
    .touch_out_oe_n(touch_out_oe_n));
  i2c_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(DEV_ADDR_DEF, a, d, nk);
    chk("write ack", 8'h00, {7'h0, nk});
  endtask
  task automatic rd(input logic [7:0] a);
    host.read2(DEV_ADDR_DEF, a, d0, d1, nk);
    chk("read ack", 8'h00, {7'h0, nk});
  endtask
  task automatic setch(input int c, input logic [9:0] v);
    sense_inputs[c*10 +: 10] <= v;
  endtask
  // bounded wait for a channel output level
  task automatic wait_out(input int c, input logic v);
    int k;
    k = 0;
    while (touch_out_oe_n[c] !== v && k < 400) begin
      w(1);
      k++;
    end
    chk("touch output", {7'h0, v}, {7'h0, touch_out_oe_n[c]});
  endtask
  // both status bytes, then the line must be released
  task automatic status(input logic [3:0] p, input logic [3:0] c);
    rd(REG_PRESSED);
    chk("pressed", {4'h0, p}, d0);
    chk("change", {4'h0, c}, d1);
    chk("irq after ack", 8'h01, {7'h0, touch_irq_n});
  endtask
  // stay away from a reference refresh
  task automatic cal_clear();
    while (cyc % CC > CC - 2500 || cyc % CC < 300) w(1);
  endtask
  task automatic t_reset();
    chk("irq idle", 8'h01, {7'h0, touch_irq_n});
    chk("outputs idle", 8'h0f, {4'h0, touch_out_oe_n});
    chk("output drive", 8'h00, {3'h0, sda_o, touch_out_o});
    rd(REG_CONFIG);
    chk("config", 8'h00, d0);
    chk("chan enable", 8'hff, d1);
    status(4'h0, 4'h0);
    wr(REG_IRQ_CFG, 8'h3f);
    wr(REG_CHANGE, 8'hff);
    host.write_reg(7'h51, REG_CONFIG, 8'h01, nk);
    chk("foreign address nack", 8'h01, {7'h0, nk});
    rd(REG_IRQ_CFG);
    chk("unused irq bits", 8'h00, d0);
    status(4'h0, 4'h0);
    $display("test reset done");
  endtask
  task automatic t_sens();
    logic [9:0] thr[4] = '{10'd32, 10'd16, 10'd64, 10'd32};
    for (int s = 0; s < 4; s++) begin
      cal_clear();
      wr(REG_CONFIG, {4'h0, s[1:0], 2'b00});
      setch(s, BASE + thr[s] - 10'd1);
      w(4 * DC);
      chk("below threshold", 8'h0f, {4'h0, touch_out_oe_n});
      setch(s, BASE + thr[s]);
      wait_out(s, 1'b0);
      w(2);
      chk("irq at touch", 8'h00, {7'h0, touch_irq_n});
      status(4'h1 << s, 4'h1 << s);
      setch(s, BASE);
      wait_out(s, 1'b1);
      w(2);
      chk("irq at release", 8'h00, {7'h0, touch_irq_n});
      status(4'h0, 4'h1 << s);
    end
    $display("test sensitivity done");
  endtask
  task automatic t_filter();
    cal_clear();
    wr(REG_CONFIG, 8'h00);
    repeat (3) begin
      setch(1, BASE + 10'd80);
      w(30);
      setch(1, BASE);
      w(2 * DC);
    end
    chk("single cycle filtered", 8'h0f, {4'h0, touch_out_oe_n});
    chk("no irq", 8'h01, {7'h0, touch_irq_n});
    $display("test filter done");
  endtask
  task automatic t_autoclear();
    int e[3] = '{ASC, ALC, 200};
    int k;
    for (int i = 1; i < 4; i++) begin
      cal_clear();
      wr(REG_IRQ_CFG, {i[1:0], 6'h00});
      setch(3, (i % 2) ? BASE + 10'd40 : BASE);
      wait_out(3, (i % 2) ? 1'b0 : 1'b1);
      w(2);
      k = 0;
      while (touch_irq_n === 1'b0 && k < 200) begin
        w(1);
        k++;
      end
      chk("auto clear time", 8'h01, {7'h0, k >= e[i-1] - 4 && k <= e[i-1] + 1});
      rd(REG_PRESSED);
      chk("pressed", (i % 2) ? 8'h08 : 8'h00, d0);
    end
    wr(REG_IRQ_CFG, 8'h00);
    setch(3, BASE);
    wait_out(3, 1'b1);
    rd(REG_PRESSED);
    $display("test auto clear done");
  endtask
  task automatic t_enable();
    cal_clear();
    wr(REG_CHAN_CTRL, 8'h0e);
    setch(0, BASE + 10'd40);
    w(6 * DC);
    chk("disabled channel", 8'h0f, {4'h0, touch_out_oe_n});
    wr(REG_CHAN_CTRL, 8'h0f);
    wait_out(0, 1'b0);
    setch(0, BASE);
    wait_out(0, 1'b1);
    rd(REG_PRESSED);
    $display("test enable done");
  endtask
  task automatic t_drift();
    cal_clear();
    setch(1, BASE + 10'd24);
    w(CC + 200);
    setch(1, BASE + 10'd48);
    w(4 * DC);
    chk("reference tracked", 8'h0f, {4'h0, touch_out_oe_n});
    setch(1, BASE + 10'd56);
    wait_out(1, 1'b0);
    setch(1, BASE);
    wait_out(1, 1'b1);
    rd(REG_PRESSED);
    $display("test drift done");
  endtask
  task automatic t_shutdown();
    cal_clear();
    wr(REG_CONFIG, 8'h01);
    setch(2, BASE + 10'd40);
    w(6 * DC);
    chk("soft shutdown", 8'h0f, {4'h0, touch_out_oe_n});
    rd(REG_CONFIG);
    chk("config kept", 8'h01, d0);
    wr(REG_CONFIG, 8'h00);
    wait_out(2, 1'b0);
    shutdown_pin_n <= 1'b0;
    setch(2, BASE);
    w(6 * DC);
    status(4'h4, 4'h4);
    shutdown_pin_n <= 1'b1;
    wait_out(2, 1'b1);
    status(4'h0, 4'h4);
    $display("test shutdown done");
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    w(6);
    rst <= 1'b0;
    w(4);
    t_reset();
    t_sens();
    t_filter();
    t_autoclear();
    t_enable();
    t_drift();
    t_shutdown();
    summarize();
  end
  // hang guard well beyond the expected run
  initial begin
    w(95000);
    num_errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    summarize();
  end
endmodule
